// *** logic/param_data_ports.sv ***
// parameter port and data port of a network slave, with input pre-processing
//
// Notes on behaviour
// - parameter pins always bidirectional open drain
// - parameter write latches then drives pins
// - sample parameter pins 10.5-12.5 us later
// - read value is wired AND
// - parameter strobe low 6.0-6.8 us
// - io code 7 releases parameter pins later
// - first parameter output enables data exchange
// - reset: parameter register 0xF, strobe
// - data exchange drives pins, samples later
// - data strobe low 6.0-6.8 us
// - io data pins release after strobe rise
// - reset: data register 0xF, strobe
// - invert flag inverts all data inputs
// - filter needs two equal samples
// - filter blocks sampling 256 us after sampling
// - filter output zero while exchange blocked
// - filter activation by enable and gating
// - safety mode keeps filter off
// - gating uses register bit, not pin
// - parameter write clears exchange block
`timescale 1ns/1ps
`default_nettype none
`include "port_consts.svh"

module param_data_ports (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // master requests
  input  wire port_pkg::port_req_t param_wr,
  input  wire port_pkg::port_req_t data_wr,
  // configuration
  input  wire port_pkg::port_cfg_t cfg,
  // parameter pins
  input  wire logic [3:0]          param_pins_in,
  output logic      [3:0]          param_pins_out,
  output logic      [3:0]          param_pins_oe,
  output logic                     param_strobe_n,
  // data pins
  input  wire logic [3:0]          data_pins_in,
  output logic      [3:0]          data_pins_out,
  output logic      [3:0]          data_pins_oe,
  output logic                     data_strobe_n,
  // results towards the master side
  output logic      [3:0]          param_out,
  output logic      [3:0]          param_in,
  output logic                     param_in_valid,
  output logic      [3:0]          data_out,
  output logic      [3:0]          data_in,
  output logic                     data_in_valid,
  output logic                     exchange_enabled,
  output logic                     filter_active
);
  import port_pkg::*;

  // ************************************************
  // helper functions
  // ************************************************

  // delay filter selection; the gate reads the output register bit only,
  // so an outside level on that pin can never switch the filter
  function automatic logic filter_select(
    input port_cfg_t  c,
    input logic [3:0] out_bits
  );
    filter_select = c.filter_enable & ~c.safety_mode &
      ~(c.filter_gated_by_param_bit & out_bits[`PARAM_GATE_BIT]);
  endfunction

  // pins handed over to input use after a write, for one io code
  function automatic logic [3:0] release_mask(input logic [3:0] code);
    release_mask = (code == `IO_CODE_PARAM_RELEASE) ? 4'hF : 4'h0;
  endfunction

  // optional inversion of a sampled nibble, same for all channels
  function automatic logic [3:0] apply_invert(
    input logic [3:0] v,
    input logic       inv
  );
    apply_invert = v ^ {4{inv}};
  endfunction

  // ************************************************
  // exchange block flag
  // ************************************************

  logic      exchange_blocked;
  logic      next_exchange_blocked;
  port_req_t data_req;

  // set by any reset, cleared by the first parameter write after it;
  // the data port runs only its reset strobe until then, so stray exchanges do nothing
  always_comb
  begin
    next_exchange_blocked = exchange_blocked;
    if (param_wr.req)
      next_exchange_blocked = 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      exchange_blocked <= 1'b1;
    else
      exchange_blocked <= next_exchange_blocked;
  end

  assign exchange_enabled = ~exchange_blocked;

  // an exchange arriving together with the enabling write is still refused,
  // which keeps the data strobe strictly after the parameter strobe
  always_comb
  begin
    data_req.req  = data_wr.req & ~exchange_blocked;
    data_req.data = data_wr.data;
  end

  // ************************************************
  // parameter port
  // ************************************************

  logic [3:0] param_release;
  logic [3:0] param_sampled;
  logic       param_sample_done;

  // pins stay driven except in the one io code that hands them over
  // to input use after each write
  assign param_release = release_mask(cfg.io_code);

  // a write is never refused: it restarts strobe and sample timer, so the
  // last word from the master always wins, even in the middle of a cycle
  port_channel #(
    .RELEASE_CYC (`PARAM_RELEASE_CYC)
  ) u_param (
    .clk         (clk),
    .rst         (rst),
    .wr          (param_wr),
    .release_en  (param_release),
    .out_reg     (param_out),
    .pins_in     (param_pins_in),
    .pins_out    (param_pins_out),
    .pins_oe     (param_pins_oe),
    .strobe_n    (param_strobe_n),
    .sample_done (param_sample_done),
    .sampled     (param_sampled)
  );

  // the outside only has to hold still inside the sampling window, so one
  // capture at its start is enough
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      param_in       <= 4'h0;
      param_in_valid <= 1'b0;
    end
    else
    begin
      param_in_valid <= param_sample_done;
      if (param_sample_done)
        param_in <= param_sampled;
    end
  end

  // ************************************************
  // data port
  // ************************************************

  logic [3:0] data_sampled;
  logic       data_sample_done;

  // pure outputs stay driven; pins marked as i/o are handed back a few
  // cycles after the strobe rises, well before the sample point
  port_channel #(
    .RELEASE_CYC (`DATA_RELEASE_CYC)
  ) u_data (
    .clk         (clk),
    .rst         (rst),
    .wr          (data_req),
    .release_en  (cfg.data_io_mask),
    .out_reg     (data_out),
    .pins_in     (data_pins_in),
    .pins_out    (data_pins_out),
    .pins_oe     (data_pins_oe),
    .strobe_n    (data_strobe_n),
    .sample_done (data_sample_done),
    .sampled     (data_sampled)
  );

  // ************************************************
  // input pre-processing
  // ************************************************

  // the filter path sees the sample only after inversion, so a set invert
  // flag also inverts what the two-in-a-row comparison looks at
  logic [3:0]  raw_in;
  logic [3:0]  last_sample;
  logic [3:0]  next_last_sample;
  logic [3:0]  next_data_in;
  logic [11:0] block_cnt;
  logic [11:0] next_block_cnt;
  logic        sample_allowed;
  logic        take_sample;
  logic        start_block;
  logic        next_data_in_valid;

  // inversion applies to every channel before the filter
  assign raw_in = apply_invert(data_sampled, cfg.invert_inputs);

  // gating looks at the output register, never at the sensed pin level
  assign filter_active = filter_select(cfg, param_out);

  // a master repeating an exchange at once must not validate data twice;
  // a new block starts only from an accepted sample, never a refused one
  assign sample_allowed = (block_cnt == 12'h000);
  assign take_sample    = data_sample_done & (~filter_active | sample_allowed);
  assign start_block    = data_sample_done & filter_active & sample_allowed;

  // sampling block counter, restarted by every sample accepted while the filter is active; the
  // upper end of the tolerance is used, so a quick repeat is always refused
  always_comb
  begin
    next_block_cnt = block_cnt;
    if (start_block)
      next_block_cnt = 12'(`FILTER_BLOCK_CYC - 1);
    else if (block_cnt != 12'h000)
      next_block_cnt = block_cnt - 12'h001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      block_cnt <= 12'h000;
    else
      block_cnt <= next_block_cnt;
  end

  // remembered sample for the two-in-a-row comparison; a blocked
  // exchange forgets it, so the first samples after enabling start afresh
  always_comb
  begin
    next_last_sample = last_sample;
    if (exchange_blocked)
      next_last_sample = `FILTER_RESET;
    else if (take_sample)
      next_last_sample = raw_in;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      last_sample <= `FILTER_RESET;
    else
      last_sample <= next_last_sample;
  end

  // reported input: direct without the filter, otherwise only after
  // two equal samples; held at zero while the exchange is blocked
  always_comb
  begin
    next_data_in = data_in;
    if (exchange_blocked)
      next_data_in = `FILTER_RESET;
    else if (take_sample && !filter_active)
      next_data_in = raw_in;
    else if (take_sample && raw_in == last_sample)
      next_data_in = raw_in;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_in <= `FILTER_RESET;
    else
      data_in <= next_data_in;
  end

  // one-cycle pulse whenever a sample was accepted while the exchange is enabled, whether data_in changed or not;
  // a sample inside the block window gives no pulse, so the master side
  // never mistakes a repeated exchange for fresh input
  always_comb
  begin
    next_data_in_valid = take_sample & ~exchange_blocked;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_in_valid <= 1'b0;
    else
      data_in_valid <= next_data_in_valid;
  end

endmodule

`default_nettype wire

// *** logic/port_consts.svh ***
// timing counts, reset values and codes of the parameter and data ports
`ifndef PORT_CONSTS_SVH
`define PORT_CONSTS_SVH

// clock period in ns (10 MHz)
`define CLK_PERIOD_NS 100

// strobe low time, least 6.0 us, rounded up
`define STB_LOW_NS 6000
`define STB_LOW_CYC ((`STB_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// input sampling after strobe fall, least 10.5 us, rounded up
`define SAMPLE_NS 10500
`define SAMPLE_CYC ((`SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// parameter pin release after strobe fall, least 56.0 us, rounded up
`define PARAM_RELEASE_NS 56000
`define PARAM_RELEASE_CYC ((`PARAM_RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// data pin release after strobe rise, least 0.2 us, rounded up
`define DATA_HOLD_NS 200
`define DATA_HOLD_CYC ((`DATA_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_RELEASE_CYC (`STB_LOW_CYC + `DATA_HOLD_CYC)

// sampling block of the delay filter, longest 256 us, rounded down
`define FILTER_BLOCK_NS 256000
`define FILTER_BLOCK_CYC (`FILTER_BLOCK_NS / `CLK_PERIOD_NS)

// reset values and codes
`define OUT_REG_RESET 4'hF
`define FILTER_RESET 4'h0
`define IO_CODE_PARAM_RELEASE 4'h7
`define PARAM_GATE_BIT 1

`endif

// *** logic/port_pkg.sv ***
// types shared by the parameter and data port logic
`default_nettype none

package port_pkg;

  // one master request: pulse plus the four data bits it carries
  typedef struct packed {
    logic       req;
    logic [3:0] data;
  } port_req_t;

  // static configuration of the ports
  typedef struct packed {
    logic [3:0] io_code;
    logic [3:0] data_io_mask;
    logic       invert_inputs;
    logic       filter_enable;
    logic       filter_gated_by_param_bit;
    logic       safety_mode;
  } port_cfg_t;

  // phase of one port output cycle
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STROBE = 2'b01,
    ST_SETTLE = 2'b10
  } port_state_t;

endpackage

`default_nettype wire

// *** logic/port_channel.sv ***
// one four-bit open-drain port: output register, strobe, delayed input sample
`timescale 1ns/1ps
`default_nettype none
`include "port_consts.svh"

module port_channel #(
  parameter int unsigned RELEASE_CYC = 1
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // new output data from the master
  input  wire port_pkg::port_req_t wr,
  input  wire logic [3:0]        release_en,
  output logic      [3:0]        out_reg,
  // open-drain pins
  input  wire logic [3:0]        pins_in,
  output logic      [3:0]        pins_out,
  output logic      [3:0]        pins_oe,
  output logic                   strobe_n,
  // sampled inputs
  output logic                   sample_done,
  output logic      [3:0]        sampled
);
  import port_pkg::*;

  // ************************************************
  // cycle bookkeeping
  // ************************************************
  function automatic logic [9:0] cyc_max(input logic [9:0] a, input logic [9:0] b);
    cyc_max = (a > b) ? a : b;
  endfunction

  localparam logic [9:0] STB_END = 10'(`STB_LOW_CYC - 1);
  localparam logic [9:0] SMP_AT  = 10'(`SAMPLE_CYC);
  localparam logic [9:0] REL_AT  = 10'(RELEASE_CYC);
  localparam logic [9:0] END_AT  = cyc_max(SMP_AT, REL_AT);

  port_state_t state;
  logic [9:0]  cnt;
  logic [3:0]  drive;
  logic        sample_now;

  // reset starts a strobe at once, as new data would
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_STROBE;
      cnt   <= 10'h000;
    end
    else if (wr.req)
    begin
      state <= ST_STROBE;             // a new write restarts the cycle
      cnt   <= 10'h000;
    end
    else
    begin
      case (state)
        ST_STROBE:
        begin
          cnt <= cnt + 10'h001;
          if (cnt == STB_END)
            state <= ST_SETTLE;
        end
        ST_SETTLE:
        begin
          if (cnt == END_AT)
            state <= ST_IDLE;
          else
            cnt <= cnt + 10'h001;
        end
        ST_IDLE:
          cnt <= cnt;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // strobe idles high and is low only while the pulse runs
  assign strobe_n = (state != ST_STROBE);

  // output register and per-pin driver enables
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_reg <= `OUT_REG_RESET;
      drive   <= 4'h0;                // drivers released
    end
    else if (wr.req)
    begin
      out_reg <= wr.data;
      drive   <= 4'hF;
    end
    else if (state == ST_SETTLE && cnt == REL_AT)
      drive <= drive & ~release_en;
  end

  // open drain: only a low is ever driven
  assign pins_out = 4'h0;
  assign pins_oe  = drive & ~out_reg;

  // input sample a fixed time after the strobe fall
  assign sample_now = (state == ST_SETTLE) && (cnt == SMP_AT);

  // wired AND of our own low drive and the outside level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sampled     <= 4'h0;
      sample_done <= 1'b0;
    end
    else
    begin
      sample_done <= sample_now;
      if (sample_now)
        sampled <= pins_in & ~pins_oe;
    end
  end

endmodule

`default_nettype wire

// *** testbench/port_load.sv ***
// model of the application circuitry on one open-drain port
`timescale 1ns/1ps
`default_nettype none
// ****
// pin load
// ****
module port_load (
  // block side of the port
  input  wire logic [3:0] oe,
  input  wire logic [3:0] out,
  // level the application drives, high = released
  input  wire logic [3:0] ext,
  // resolved pin level
  output logic      [3:0] pins
);
  // pull-ups: a pin is low when either party pulls it, ext is only
  // changed between sampling windows by the bench
  assign pins = ext & ~(oe & ~out);
endmodule
`default_nettype wire

// *** testbench/param_data_ports_asserts.sv ***
// timing checker for the parameter and data ports
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module param_data_ports_asserts (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // requests and configuration
  input  wire port_pkg::port_req_t param_wr,
  input  wire port_pkg::port_req_t data_wr,
  input  wire port_pkg::port_cfg_t cfg,
  // outputs
  input  wire logic [3:0]          param_pins_oe,
  input  wire logic                param_strobe_n,
  input  wire logic [3:0]          data_pins_oe,
  input  wire logic                data_strobe_n,
  input  wire logic [3:0]          param_out,
  input  wire logic                param_in_valid,
  input  wire logic [3:0]          data_out,
  input  wire logic [3:0]          data_in,
  input  wire logic                exchange_enabled,
  input  wire logic                filter_active
);
  import port_pkg::*;
  logic [11:0] pc;
  logic [11:0] dc;
  logic        ps;
  logic        ds;
  logic        dacc;
  // a refused exchange must not restart the data count
  assign dacc = data_wr.req & exchange_enabled;
  // cycles since the last parameter write or reset, saturating
  always_ff @(posedge clk or posedge rst)
    if (rst)
      pc <= 12'h001;
    else if (param_wr.req)
      pc <= 12'h001;
    else if (pc != 12'hFFF)
      pc <= pc + 12'h001;
  // cycles since the last accepted exchange or reset
  always_ff @(posedge clk or posedge rst)
    if (rst)
      dc <= 12'h001;
    else if (dacc)
      dc <= 12'h001;
    else if (dc != 12'hFFF)
      dc <= dc + 12'h001;
  // a write has been seen since reset
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ps <= 1'b0;
    else if (param_wr.req)
      ps <= 1'b1;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ds <= 1'b0;
    else if (dacc)
      ds <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_p_wait;
    ps && pc == 12'h064;
  endsequence
  sequence s_d_out;
    !data_strobe_n && data_out == $past(data_wr.data);
  endsequence
  a_pstb_low: assert property (pc <= 12'h03C |-> !param_strobe_n)
    else $error("param strobe high too early");
  a_pstb_high: assert property (pc >= 12'h03D |-> param_strobe_n)
    else $error("param strobe low too long");
  a_dstb_low: assert property (dc <= 12'h03C |-> !data_strobe_n)
    else $error("data strobe high too early");
  a_dstb_high: assert property (dc >= 12'h03D |-> data_strobe_n)
    else $error("data strobe low too long");
  a_pwr_latch: assert property (param_wr.req |=>
    param_out == $past(param_wr.data) && exchange_enabled)
    else $error("param write not latched");
  a_pin_drive: assert property (ps && !param_wr.req
    && (cfg.io_code != 4'h7 || pc <= 12'h231) |-> param_pins_oe == ~param_out)
    else $error("param pins not driven");
  a_pin_release: assert property (ps && cfg.io_code == 4'h7 && pc >= 12'h232
    |-> param_pins_oe == 4'h0) else $error("param pins not released");
  a_psample_due: assert property (s_p_wait |-> ##[1:25] param_in_valid)
    else $error("param sample missing");
  a_reset_vals: assert property ($past(rst) |-> param_out == 4'hF
    && data_out == 4'hF && param_pins_oe == 4'h0 && data_pins_oe == 4'h0)
    else $error("bad reset state");
  a_data_take: assert property (dacc |=> s_d_out)
    else $error("exchange not taken");
  a_data_refuse: assert property (data_wr.req && !exchange_enabled |=> $stable(data_out))
    else $error("exchange taken while blocked");
  a_io_release: assert property (ds && !dacc && dc >= 12'h040
    |-> data_pins_oe == (~data_out & ~cfg.data_io_mask)) else $error("io pin release");
  a_filter_sel: assert property (filter_active == (cfg.filter_enable
    && !cfg.safety_mode && !(cfg.filter_gated_by_param_bit && param_out[1])))
    else $error("filter select");
  a_filter_zero: assert property (!exchange_enabled |-> data_in == 4'h0)
    else $error("filter output not cleared");
endmodule
bind param_data_ports param_data_ports_asserts i_param_data_ports_asserts (
  .clk(clk), .rst(rst), .param_wr(param_wr), .data_wr(data_wr), .cfg(cfg),
  .param_pins_oe(param_pins_oe), .param_strobe_n(param_strobe_n),
  .data_pins_oe(data_pins_oe), .data_strobe_n(data_strobe_n), .param_out(param_out),
  .param_in_valid(param_in_valid), .data_out(data_out), .data_in(data_in),
  .exchange_enabled(exchange_enabled), .filter_active(filter_active));
`default_nettype wire

// *** testbench/tb_param_data_ports.sv ***
// self-checking bench for the parameter and data ports
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb_param_data_ports;
  import port_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  port_req_t  param_wr = '0;
  port_req_t  data_wr = '0;
  port_cfg_t  cfg = '0;
  logic [3:0] ext_p = 4'hF;
  logic [3:0] ext_d = 4'hF;
  logic [3:0] pp_in, pp_out, pp_oe, dp_in, dp_out, dp_oe, p_in, d_in, a;
  logic       p_v, d_v;
  logic [4:0] pq[$];
  logic [4:0] dq[$];
  int         miscompares = 0;
  int         checks_done = 0;
  int         i;
  always #50 clk = ~clk;
  param_data_ports i_param_data_ports (
    .clk(clk), .rst(rst), .param_wr(param_wr), .data_wr(data_wr), .cfg(cfg),
    .param_pins_in(pp_in), .param_pins_out(pp_out), .param_pins_oe(pp_oe),
    .param_strobe_n(), .data_pins_in(dp_in), .data_pins_out(dp_out),
    .data_pins_oe(dp_oe), .data_strobe_n(), .param_out(), .param_in(p_in),
    .param_in_valid(p_v), .data_out(), .data_in(d_in), .data_in_valid(d_v),
    .exchange_enabled(), .filter_active());
  port_load i_port_load (.oe(pp_oe), .out(pp_out), .ext(ext_p), .pins(pp_in));
  port_load i_port_load_d (.oe(dp_oe), .out(dp_out), .ext(ext_d), .pins(dp_in));
  // bit 4 of a note means any value; an empty queue never matches
  task chk(input logic [3:0] got, input logic [4:0] exp);
    checks_done++;
    if (exp[4] !== 1'b1 && got !== exp[3:0])
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp[3:0]);
    end
  endtask
  // results are matched against notes in request order; they are read at
  // the falling edge, where the registered outputs have settled
  always @(negedge clk)
  begin
    if (p_v === 1'b1) chk(p_in, pq.size() ? pq.pop_front() : 5'bx);
    if (d_v === 1'b1) chk(d_in, dq.size() ? dq.pop_front() : 5'bx);
  end
  task pwrite(input logic [3:0] v);
    param_wr = '{1'b1, v};
    pq.push_back({1'b0, v & ext_p});
    @(negedge clk);
    param_wr.req = 1'b0;
    repeat (120) @(negedge clk);
  endtask
  // e[5] asks for a note, e[4:0] is the note
  task dwrite(input logic [3:0] v, input int gap, input logic [5:0] e);
    data_wr = '{1'b1, v};
    if (e[5]) dq.push_back(e[4:0]);
    @(negedge clk);
    data_wr.req = 1'b0;
    repeat (gap) @(negedge clk);
  endtask
  task give_verdict;
    if (pq.size() + dq.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog sized well above the planned run of about 14000 cycles
  initial
  begin
    #3000000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h2d729e6c));
    ext_p = 4'($urandom);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    pq.push_back({1'b0, ext_p});
    dwrite(4'h0, 150, 6'h00);
    $display("test reset done");
    // random flags exercise the filter selection; code 7 comes last
    for (i = 0; i < 4; i++)
    begin
      cfg = {(i == 3) ? 4'h7 : 4'($urandom_range(6, 0)), 8'($urandom)};
      pwrite(4'($urandom));
    end
    repeat (500) @(negedge clk);
    $display("test param done");
    for (i = 0; i < 6; i++)
    begin
      cfg = {cfg.io_code, 4'($urandom), 1'($urandom), 1'b0, cfg[1:0]};
      ext_d = 4'($urandom);
      a = 4'($urandom);
      dwrite(a, 150, {2'b10, (ext_d & (a | cfg.data_io_mask)) ^ {4{cfg.invert_inputs}}});
    end
    $display("test data done");
    repeat (2700) @(negedge clk);
    cfg = {4'h7, 4'h0, 1'b0, 1'b1, 2'b00};
    ext_d = 4'hF;
    a = 4'($urandom);
    dwrite(a, 2700, 6'h30);
    dwrite(a, 300, {2'b10, a});
    dwrite(~a, 2700, 6'h00);
    dwrite(~a, 2700, {2'b10, a});
    dwrite(~a, 200, {2'b10, ~a});
    $display("test filter done");
    // second reset in mid-run
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    pq.push_back({1'b0, ext_p});
    repeat (150) @(negedge clk);
    $display("test rereset done");
    give_verdict();
  end
endmodule
`default_nettype wire
